// ===== design/flash_cmd_regs.svh
// opcode values, field positions, reset values and register map
//
// Summary of operation
// - opcode 06 sets write-enable latch
// - opcode 04 clears write-enable latch, both modes
// - opcode 05 shifts out status register
// - opcode 15 shifts out configuration register
// - opcode 01 writes status, then optional config
// - opcode 68 enables individual block protection
// - B0 suspends, 30 resumes program/erase
// - B9 enters, AB leaves deep power-down
// - 35 in single-line mode enters quad mode
// - F5 in quad mode returns to single-line
`ifndef FLASH_CMD_REGS_SVH
`define FLASH_CMD_REGS_SVH

`define SET_WRITE_LATCH_CMD 8'h06
`define CLEAR_WRITE_LATCH_CMD 8'h04
`define STATUS_READ_CMD 8'h05
`define CONFIG_READ_CMD 8'h15
`define STATUS_CONFIG_WRITE_CMD 8'h01
`define BLOCK_PROTECT_SELECT_CMD 8'h68
`define QUAD_MODE_ENTRY_CMD 8'h35
`define QUAD_MODE_EXIT_CMD 8'hF5
`define PROGRAM_ERASE_PAUSE_CMD 8'hB0
`define PROGRAM_ERASE_CONTINUE_CMD 8'h30
`define DEEP_SLEEP_ENTRY_CMD 8'hB9
`define DEEP_SLEEP_EXIT_CMD 8'hAB
`define BURST_LENGTH_SET_CMD 8'hC0
`define BOOT_REGISTER_READ_CMD 8'h16
`define BOOT_REGISTER_WRITE_CMD 8'h17
`define BOOT_REGISTER_ERASE_CMD 8'h18

`define WRITE_LATCH_BIT 1
`define STATUS_RESET 8'h00
`define CONFIG_RESET 8'h00
`define BURST_RESET 8'h00
`define BOOT_RESET 32'hFFFF_FFFF

// apb register offsets
`define REG_STATE 12'h000
`define REG_STATUS 12'h004
`define REG_CONFIG 12'h008
`define REG_BURST 12'h00C
`define REG_BOOT 12'h010
`define REG_LAST_OP 12'h014

`endif

// ===== design/flash_cmd_pkg.sv
// types shared by the flash setting command decoder
`default_nettype none
package flash_cmd_pkg;
  typedef enum logic [1:0] {
    PH_OPCODE = 2'b00,
    PH_DATA_IN = 2'b01,
    PH_DATA_OUT = 2'b10,
    PH_IGNORE = 2'b11
  } phase_e;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic [3:0] dio;
  } link_in_s;

  typedef struct packed {
    logic [3:0] dout;
    logic [3:0] doe;
  } link_out_s;

  typedef struct packed {
    logic write_enable_latch;
    logic block_protect;
    logic quad_command_mode;
    logic suspended;
    logic deep_sleep;
  } flags_s;
endpackage : flash_cmd_pkg
`default_nettype wire

// ===== design/flash_cmd_decoder.sv
// opcode decoder for register and setting commands on a serial flash link
//
// The implementer's own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_cmd_regs.svh"

module flash_cmd_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire flash_cmd_pkg::link_in_s link_in,
  output flash_cmd_pkg::link_out_s link_out
);

  typedef struct packed {
    flash_cmd_pkg::link_in_s sync1;
    flash_cmd_pkg::link_in_s sync2;
    logic sck_prev;
    logic cs_prev;
    flash_cmd_pkg::phase_e phase;
    logic [7:0] opcode;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic [2:0] bytecnt;
    logic [31:0] out_word;
    logic [31:0] boot_acc;
    flash_cmd_pkg::flags_s flags;
    logic [7:0] status;
    logic [7:0] config_r;
    logic [7:0] burst;
    logic [31:0] boot;
    logic [7:0] last_op;
    flash_cmd_pkg::link_out_s lout;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_s;

  state_s state_reg;
  state_s state_next;

  // opcode legality per command mode
  function automatic logic op_valid(input logic [7:0] op, input logic quad);
    unique case (op)
      `SET_WRITE_LATCH_CMD, `CLEAR_WRITE_LATCH_CMD, `STATUS_READ_CMD,
      `CONFIG_READ_CMD, `STATUS_CONFIG_WRITE_CMD, `BLOCK_PROTECT_SELECT_CMD,
      `PROGRAM_ERASE_PAUSE_CMD, `PROGRAM_ERASE_CONTINUE_CMD,
      `DEEP_SLEEP_ENTRY_CMD, `DEEP_SLEEP_EXIT_CMD, `BURST_LENGTH_SET_CMD:
        op_valid = 1'b1;
      `QUAD_MODE_ENTRY_CMD, `BOOT_REGISTER_READ_CMD,
      `BOOT_REGISTER_WRITE_CMD, `BOOT_REGISTER_ERASE_CMD:
        op_valid = !quad;
      `QUAD_MODE_EXIT_CMD: op_valid = quad;
      default: op_valid = 1'b0;
    endcase
  endfunction : op_valid

  ////////////////////////////////////////////////////////////////////////////
  logic sck_rise;
  logic sck_fall;
  logic cs_active;
  logic quad;
  logic [3:0] step;
  logic [7:0] byte_in;
  logic byte_done;

  always_comb begin
    state_next = state_reg;
    quad = state_reg.flags.quad_command_mode;
    step = quad ? 4'h4 : 4'h1;
    sck_rise = state_reg.sync2.sck & ~state_reg.sck_prev;
    sck_fall = ~state_reg.sync2.sck & state_reg.sck_prev;
    cs_active = ~state_reg.sync2.cs_n;
    byte_in = quad ? {state_reg.shift[3:0], state_reg.sync2.dio}
                   : {state_reg.shift[6:0], state_reg.sync2.dio[0]};
    byte_done = (state_reg.bitcnt + step) == 4'h8;

    state_next.sync1 = link_in;
    state_next.sync2 = state_reg.sync1;
    state_next.sck_prev = state_reg.sync2.sck;
    state_next.cs_prev = state_reg.sync2.cs_n;

    if (!cs_active) begin
      // frame end: commit writes whose data arrived complete
      if (!state_reg.cs_prev && state_reg.phase == flash_cmd_pkg::PH_DATA_IN
          && state_reg.opcode == `BOOT_REGISTER_WRITE_CMD
          && state_reg.bytecnt == 3'h4)
      begin
        state_next.boot = state_reg.boot_acc;
        state_next.flags.write_enable_latch = 1'b0;
      end
      if (!state_reg.cs_prev && state_reg.phase == flash_cmd_pkg::PH_DATA_IN
          && state_reg.opcode == `STATUS_CONFIG_WRITE_CMD
          && state_reg.bytecnt != 3'h0)
        state_next.flags.write_enable_latch = 1'b0;
      state_next.phase = flash_cmd_pkg::PH_OPCODE;
      state_next.bitcnt = 4'h0;
      state_next.bytecnt = 3'h0;
      state_next.lout.doe = 4'h0;
    end else if (sck_rise && state_reg.phase != flash_cmd_pkg::PH_DATA_OUT
                 && state_reg.phase != flash_cmd_pkg::PH_IGNORE) begin
      state_next.shift = byte_in;
      state_next.bitcnt = byte_done ? 4'h0 : state_reg.bitcnt + step;
      if (byte_done && state_reg.phase == flash_cmd_pkg::PH_OPCODE) begin
        state_next.opcode = byte_in;
        state_next.phase = flash_cmd_pkg::PH_IGNORE;
        // deep sleep answers only its exit opcode
        if (op_valid(byte_in, quad) && (!state_reg.flags.deep_sleep
            || byte_in == `DEEP_SLEEP_EXIT_CMD)) begin
          state_next.last_op = byte_in;
          unique case (byte_in)
            `SET_WRITE_LATCH_CMD:
              state_next.flags.write_enable_latch = 1'b1;
            `CLEAR_WRITE_LATCH_CMD:
              state_next.flags.write_enable_latch = 1'b0;
            `STATUS_READ_CMD: begin
              state_next.phase = flash_cmd_pkg::PH_DATA_OUT;
              state_next.out_word = {state_reg.status, 24'h00_0000};
            end
            `CONFIG_READ_CMD: begin
              state_next.phase = flash_cmd_pkg::PH_DATA_OUT;
              state_next.out_word = {state_reg.config_r, 24'h00_0000};
            end
            `BOOT_REGISTER_READ_CMD: begin
              state_next.phase = flash_cmd_pkg::PH_DATA_OUT;
              state_next.out_word = state_reg.boot;
            end
            `STATUS_CONFIG_WRITE_CMD, `BURST_LENGTH_SET_CMD,
            `BOOT_REGISTER_WRITE_CMD:
              state_next.phase = flash_cmd_pkg::PH_DATA_IN;
            `BLOCK_PROTECT_SELECT_CMD:
              state_next.flags.block_protect = 1'b1;
            `QUAD_MODE_ENTRY_CMD:
              state_next.flags.quad_command_mode = 1'b1;
            `QUAD_MODE_EXIT_CMD:
              state_next.flags.quad_command_mode = 1'b0;
            `PROGRAM_ERASE_PAUSE_CMD:
              state_next.flags.suspended = 1'b1;
            `PROGRAM_ERASE_CONTINUE_CMD:
              state_next.flags.suspended = 1'b0;
            `DEEP_SLEEP_ENTRY_CMD:
              state_next.flags.deep_sleep = 1'b1;
            `DEEP_SLEEP_EXIT_CMD:
              state_next.flags.deep_sleep = 1'b0;
            `BOOT_REGISTER_ERASE_CMD: begin
              state_next.boot = `BOOT_RESET;
              state_next.flags.write_enable_latch = 1'b0;
            end
            default: state_next.phase = flash_cmd_pkg::PH_IGNORE;
          endcase
        end
      end else if (byte_done) begin
        // saturate so an overlong frame never wraps back to a full count
        if (state_reg.bytecnt != 3'h7)
          state_next.bytecnt = state_reg.bytecnt + 3'h1;
        unique case (state_reg.opcode)
          `STATUS_CONFIG_WRITE_CMD: begin
            if (state_reg.bytecnt == 3'h0)
              state_next.status = byte_in;
            else if (state_reg.bytecnt == 3'h1)
              state_next.config_r = byte_in;
            else
              state_next.phase = flash_cmd_pkg::PH_IGNORE;
          end
          `BURST_LENGTH_SET_CMD: begin
            state_next.burst = byte_in;
            state_next.phase = flash_cmd_pkg::PH_IGNORE;
          end
          `BOOT_REGISTER_WRITE_CMD: begin
            if (state_reg.bytecnt < 3'h4)
              state_next.boot_acc = {state_reg.boot_acc[23:0], byte_in};
          end
          default: state_next.phase = flash_cmd_pkg::PH_IGNORE;
        endcase
      end
    end else if (sck_fall && state_reg.phase == flash_cmd_pkg::PH_DATA_OUT)
    begin
      // shift out msb first on falling edge, host samples on rising
      state_next.lout.doe = quad ? 4'hF : 4'h2;
      state_next.lout.dout = quad ? state_reg.out_word[31:28]
                                  : {2'b00, state_reg.out_word[31], 1'b0};
      state_next.out_word = quad ? {state_reg.out_word[27:0], 4'h0}
                                 : {state_reg.out_word[30:0], 1'b0};
      // status/config rotate their one byte so every read byte repeats it
      if (state_reg.opcode != `BOOT_REGISTER_READ_CMD)
        state_next.out_word[31:24] = quad
            ? {state_reg.out_word[27:24], state_reg.out_word[31:28]}
            : {state_reg.out_word[30:24], state_reg.out_word[31]};
    end

    // mirror latch bit into status byte
    state_next.status[`WRITE_LATCH_BIT] = state_next.flags.write_enable_latch;

    //////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states
    state_next.pready = 1'b0;
    state_next.pslverr = 1'b0;
    if (psel && !penable) begin
      state_next.pready = 1'b1;
      state_next.prdata = 32'h0000_0000;
      unique case (paddr)
        `REG_STATE: state_next.prdata = {27'h000_0000, state_reg.flags};
        `REG_STATUS: state_next.prdata = {24'h00_0000, state_reg.status};
        `REG_CONFIG: state_next.prdata = {24'h00_0000, state_reg.config_r};
        `REG_BURST: state_next.prdata = {24'h00_0000, state_reg.burst};
        `REG_BOOT: state_next.prdata = state_reg.boot;
        `REG_LAST_OP: state_next.prdata = {24'h00_0000, state_reg.last_op};
        default: state_next.pslverr = 1'b1;
      endcase
      // software may preset burst length; link writes that change its value take priority
      if (pwrite && paddr == `REG_BURST && state_next.burst == state_reg.burst)
        state_next.burst = pwdata[7:0];
      if (pwrite && paddr != `REG_BURST)
        state_next.pslverr = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.sync1.cs_n <= 1'b1;
      state_reg.sync2.cs_n <= 1'b1;
      state_reg.cs_prev <= 1'b1;
      state_reg.status <= `STATUS_RESET;
      state_reg.config_r <= `CONFIG_RESET;
      state_reg.burst <= `BURST_RESET;
      state_reg.boot <= `BOOT_RESET;
    end else if (clk_en) begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign link_out = state_reg.lout;
endmodule : flash_cmd_decoder
`default_nettype wire

// ===== tb/flash_cmd_decoder_monitor.sv
// port checker for the flash setting command decoder
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_decoder_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire flash_cmd_pkg::link_in_s link_in,
  input wire flash_cmd_pkg::link_out_s link_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  property p_answer; s_setup |=> pready && penable; endproperty
  a_answer: assert property (p_answer) else $error("late pready");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_unmapped; s_setup ##0 paddr > 12'h014 |=> pslverr; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no error");
  property p_read_ok;
    s_setup ##0 !pwrite && paddr[1:0] == 2'b00 && paddr <= 12'h014
      |=> !pslverr;
  endproperty
  a_read_ok: assert property (p_read_ok) else $error("read refused");
  property p_ro; s_setup ##0 pwrite && paddr != 12'h00C |=> pslverr;
  endproperty
  a_ro: assert property (p_ro) else $error("ro write taken");
  property p_burst; s_setup ##0 pwrite && paddr == 12'h00C |=> !pslverr;
  endproperty
  a_burst: assert property (p_burst) else $error("burst refused");
  property p_idle; link_in.cs_n [*5] |-> link_out.doe == 4'h0; endproperty
  a_idle: assert property (p_idle) else $error("drives idle");
  property p_lanes; link_out.doe inside {4'h0, 4'h2, 4'hF}; endproperty
  a_lanes: assert property (p_lanes) else $error("bad lanes");
endmodule : flash_cmd_decoder_monitor
bind flash_cmd_decoder flash_cmd_decoder_monitor mon_u (.pclk, .presetn,
  .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .link_in, .link_out);
`default_nettype wire

// ===== tb/flash_host_model.sv
// serial host that frames commands on the flash link
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  output var flash_cmd_pkg::link_in_s link_in,
  input wire flash_cmd_pkg::link_out_s link_out
);
  initial link_in = '{sck: 1'b0, cs_n: 1'b1, dio: 4'h0};
  // one command per frame; sck rests low between frames
  task automatic xfer(input logic q, input int nb, input logic [39:0] tx,
                      input int nr, output logic [31:0] rx);
    int w;
    w = q ? 4 : 1;
    rx = '0;
    #3 link_in.cs_n = 1'b0;
    #64;
    for (int i = 0; i < nb * 8; i += w) begin
      link_in.dio = q ? tx[39 - i -: 4] : {3'b000, tx[39 - i]};
      #32 link_in.sck = 1'b1;
      #32 link_in.sck = 1'b0;
    end
    for (int i = 0; i < nr * 8; i += w) begin
      // released lines toggle so a stale value is never mistaken
      link_in.dio = ~link_in.dio;
      #32 link_in.sck = 1'b1;
      rx = q ? {rx[27:0], link_out.dout} : {rx[30:0], link_out.dout[1]};
      #32 link_in.sck = 1'b0;
    end
    #64 link_in.cs_n = 1'b1;
    link_in.dio = ~link_in.dio;
    #200;
  endtask : xfer
endmodule : flash_host_model
`default_nettype wire

// ===== tb/testbench.sv
// apb and link driven bench for the flash setting command decoder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] r;
  logic pready;
  logic pslverr;
  logic e;
  int mismatches = 0;
  int cmp_count = 0;
  flash_cmd_pkg::link_in_s link_in;
  flash_cmd_pkg::link_out_s link_out;
  always #4 pclk = ~pclk;
  flash_cmd_decoder dut_u (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_in(link_in), .link_out(link_out));
  flash_host_model host_u (.link_in(link_in), .link_out(link_out));
  ////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    if (mismatches == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      mismatches++;
      $display("BAD %0t seen %h want %h", $time, s, x);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      final_report();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(r, x);
  endtask : rd
  task automatic cmd(input logic q, input int nb, input logic [39:0] tx);
    host_u.xfer(q, nb, tx, 0, r);
  endtask : cmd
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h0000_0000);
    rd(12'h010, 32'hFFFF_FFFF);
    apb(1'b0, 12'h018, 32'h0000_0000);
    chk({31'b0, e}, 32'h0000_0001);
    apb(1'b1, 12'h004, 32'h0000_00FF);
    chk({31'b0, e}, 32'h0000_0001);
    apb(1'b1, 12'h00C, 32'h0000_0061);
    rd(12'h00C, 32'h0000_0061);
    cmd(1'b0, 2, {8'hC0, 8'h47, 24'h0});
    rd(12'h00C, 32'h0000_0047);
    cmd(1'b0, 1, {8'h06, 32'h0});
    rd(12'h000, 32'h0000_0010);
    host_u.xfer(1'b0, 1, {8'h05, 32'h0}, 2, r);
    chk(r, 32'h0000_0202);
    cmd(1'b0, 1, {8'h04, 32'h0});
    rd(12'h000, 32'h0000_0000);
    cmd(1'b0, 3, {8'h01, 8'h3C, 8'h5A, 16'h0});
    rd(12'h008, 32'h0000_005A);
    cmd(1'b0, 2, {8'h01, 8'h1C, 24'h0});
    rd(12'h004, 32'h0000_001C);
    host_u.xfer(1'b0, 1, {8'h15, 32'h0}, 1, r);
    chk(r, 32'h0000_005A);
    cmd(1'b0, 1, {8'h68, 32'h0});
    rd(12'h000, 32'h0000_0008);
    cmd(1'b0, 1, {8'hB0, 32'h0});
    rd(12'h000, 32'h0000_000A);
    cmd(1'b0, 1, {8'h30, 32'h0});
    rd(12'h000, 32'h0000_0008);
    cmd(1'b0, 1, {8'hB9, 32'h0});
    cmd(1'b0, 1, {8'h06, 32'h0});
    rd(12'h000, 32'h0000_0009);
    cmd(1'b0, 1, {8'hAB, 32'h0});
    cmd(1'b0, 1, {8'hF5, 32'h0});
    rd(12'h000, 32'h0000_0008);
    cmd(1'b0, 1, {8'h35, 32'h0});
    rd(12'h000, 32'h0000_000C);
    cmd(1'b1, 5, {8'h17, 32'h1234_5678});
    rd(12'h010, 32'hFFFF_FFFF);
    cmd(1'b1, 1, {8'h06, 32'h0});
    host_u.xfer(1'b1, 1, {8'h05, 32'h0}, 2, r);
    chk(r, 32'h0000_1E1E);
    cmd(1'b1, 1, {8'h04, 32'h0});
    cmd(1'b1, 1, {8'hF5, 32'h0});
    rd(12'h000, 32'h0000_0008);
    // frozen block must not see a whole frame
    clk_en <= 1'b0;
    cmd(1'b0, 1, {8'h06, 32'h0});
    clk_en <= 1'b1;
    rd(12'h000, 32'h0000_0008);
    cmd(1'b0, 5, {8'h17, 32'h1234_5678});
    host_u.xfer(1'b0, 1, {8'h16, 32'h0}, 4, r);
    chk(r, 32'h1234_5678);
    cmd(1'b0, 1, {8'h18, 32'h0});
    rd(12'h010, 32'hFFFF_FFFF);
    rd(12'h014, 32'h0000_0018);
    final_report();
  end
endmodule : testbench
`default_nettype wire
